/* File: logic/thermal_window_comparator.sv */
/*
 * thermal window comparator core: conversion timer, result register,
 * setpoints with hysteresis and fault queue, window and critical alarm
 * pins, apb register slave.
 * assumes a serial front end that shifts a 10-bit result msb first on
 * rising sens_clk edges while sens_frame is high, and pull-ups on the
 * open-drain alarm pins.
 */
`timescale 1ns/10ps
// Operation
// - window alarm when result outside low/high
// - critical alarm when result above critical
// - window alarm has comparator and event modes
// - critical alarm always in comparator mode
// - host writes setpoints, device uses them
// - programmable hysteresis and fault queue
// - two straps select bus address
// - power-up setpoint defaults 2/10/64/80 degrees
// - result is 10-bit signed, half degree
// - conversion every 70 ms, then restart
// - reads anytime return last completed result
// - read aborts and restarts running conversion
// - low release at low plus hysteresis
// - high/critical release at setpoint minus hysteresis
// - comparator mode: read clears until next result
// - event mode: read clears until next crossing
// - read clears critical alarm until conversion ends
// - status flags untouched by reads
module thermal_window_comparator #(
  parameter int unsigned CONV_CYCLES = thermal_pkg::CONV_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sens_clk,
  input wire logic sens_dat,
  input wire logic sens_frame,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic window_alarm_in,
  output logic window_alarm_out,
  output logic window_alarm_oe_n,
  input wire logic critical_alarm_in,
  output logic critical_alarm_out,
  output logic critical_alarm_oe_n
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pin_sync_if #(.W(3)) link_pins ();
  pin_sync_if #(.W(2)) strap_pins ();

  logic [9:0] shift_q;
  logic [9:0] sample_q;
  logic clk_prev_q;
  logic frame_prev_q;
  logic link_rise;
  logic frame_fall;

  logic [thermal_pkg::CONV_W-1:0] conv_cnt_q;
  logic conv_done;
  logic eval_q;
  logic [9:0] temp_q;

  logic [3:0] config_q;
  logic [9:0] hyst_q;
  logic [9:0] low_q;
  logic [9:0] high_q;
  logic [9:0] crit_q;

  logic [2:0] flag_q;
  logic [1:0] win_prev_q;
  logic [2:0] set_c;
  logic [2:0] clr_c;
  logic [2:0] fq_cnt_q [3];
  logic [2:0] fq_need;
  logic win_alarm_q;
  logic crit_alarm_q;
  logic [6:0] bus_addr_q;

  logic setup;
  logic access;
  logic rd_hit;
  logic mapped;
  logic writable;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  assign link_pins.raw = {sens_frame, sens_dat, sens_clk};
  assign strap_pins.raw = {addr_strap_bit1, addr_strap_bit0};

  pin_sync #(.W(3)) u_link_sync (
    .pclk (pclk),
    .presetn (presetn),
    .sig (link_pins.sync_side)
  );

  pin_sync #(.W(2)) u_strap_sync (
    .pclk (pclk),
    .presetn (presetn),
    .sig (strap_pins.sync_side)
  );

  // ----------------------------------------
  // front end link
  // ----------------------------------------
  assign link_rise = link_pins.clean[0] & ~clk_prev_q;
  assign frame_fall = frame_prev_q & ~link_pins.clean[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 1'b0;
      frame_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= link_pins.clean[0];
      frame_prev_q <= link_pins.clean[2];
    end
  end

  // shorter frames leave stale upper bits; a frame is 10 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= '0;
      sample_q <= '0;
    end else begin
      if (link_rise && link_pins.clean[2]) begin
        shift_q <= {shift_q[8:0], link_pins.clean[1]};
      end
      if (frame_fall) begin
        sample_q <= shift_q;
      end
    end
  end

  // ----------------------------------------
  // conversion timer
  // ----------------------------------------
  assign conv_done = !config_q[thermal_pkg::CFG_SHUTDOWN] &&
    (conv_cnt_q == thermal_pkg::CONV_W'(CONV_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt_q <= '0;
    end else if (config_q[thermal_pkg::CFG_SHUTDOWN]) begin
      conv_cnt_q <= '0;
    end else if (rd_hit || conv_done) begin
      conv_cnt_q <= '0;
    end else begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  // result only moves at the end of a conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_q <= '0;
      eval_q <= 1'b0;
    end else begin
      eval_q <= conv_done;
      if (conv_done) begin
        temp_q <= sample_q;
      end
    end
  end

  // ----------------------------------------
  // limit compare
  // ----------------------------------------
  // one extra bit so setpoint plus or minus hysteresis cannot wrap
  function automatic logic signed [10:0] ext(input logic [9:0] v);
    ext = {v[9], v};
  endfunction

  // judged on the result being stored, so alarms never trail a conversion
  always_comb begin
    set_c[0] = ext(sample_q) < ext(low_q);
    clr_c[0] = ext(sample_q) > ext(low_q) + ext(hyst_q);
    set_c[1] = ext(sample_q) > ext(high_q);
    clr_c[1] = ext(sample_q) < ext(high_q) - ext(hyst_q);
    set_c[2] = ext(sample_q) > ext(crit_q);
    clr_c[2] = ext(sample_q) < ext(crit_q) - ext(hyst_q);
  end

  always_comb begin
    unique case (config_q[thermal_pkg::CFG_FQ_LSB +: 2])
      2'd0: fq_need = thermal_pkg::FQ_DEPTH0;
      2'd1: fq_need = thermal_pkg::FQ_DEPTH1;
      2'd2: fq_need = thermal_pkg::FQ_DEPTH2;
      2'd3: fq_need = thermal_pkg::FQ_DEPTH3;
    endcase
  end

  // flags see only results and limits, never the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
      for (int i = 0; i < 3; i++) begin
        fq_cnt_q[i] <= '0;
      end
    end else if (conv_done) begin
      for (int i = 0; i < 3; i++) begin
        if (!flag_q[i]) begin
          if (!set_c[i]) begin
            fq_cnt_q[i] <= '0;
          end else if (fq_cnt_q[i] + 3'h1 >= fq_need) begin
            flag_q[i] <= 1'b1;
            fq_cnt_q[i] <= '0;
          end else begin
            fq_cnt_q[i] <= fq_cnt_q[i] + 3'h1;
          end
        end else if (clr_c[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // alarm outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_prev_q <= '0;
    end else if (eval_q) begin
      win_prev_q <= flag_q[1:0];
    end
  end

  // a finished conversion beats a read in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_alarm_q <= 1'b0;
    end else if (eval_q && config_q[thermal_pkg::CFG_EVENT]) begin
      if (flag_q[1:0] != win_prev_q) begin
        win_alarm_q <= 1'b1;
      end else if (rd_hit) begin
        win_alarm_q <= 1'b0;
      end
    end else if (eval_q) begin
      win_alarm_q <= |flag_q[1:0];
    end else if (rd_hit) begin
      win_alarm_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crit_alarm_q <= 1'b0;
    end else if (eval_q) begin
      crit_alarm_q <= flag_q[2];
    end else if (rd_hit) begin
      crit_alarm_q <= 1'b0;
    end
  end

  // open drain: pull low while the alarm is active
  assign window_alarm_out = 1'b0;
  assign window_alarm_oe_n = ~win_alarm_q;
  assign critical_alarm_out = 1'b0;
  assign critical_alarm_oe_n = ~crit_alarm_q;

  // ----------------------------------------
  // bus address straps
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_addr_q <= '0;
    end else begin
      bus_addr_q <= {thermal_pkg::BUS_ADDR_BASE, strap_pins.clean};
    end
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    writable = 1'b1;
    unique case (paddr)
      thermal_pkg::OFF_TEMP: writable = 1'b0;
      thermal_pkg::OFF_STATUS: writable = 1'b0;
      thermal_pkg::OFF_CONFIG, thermal_pkg::OFF_HYST,
      thermal_pkg::OFF_LOW, thermal_pkg::OFF_HIGH,
      thermal_pkg::OFF_CRIT: writable = 1'b1;
      default: begin
        mapped = 1'b0;
        writable = 1'b0;
      end
    endcase
  end

  // any mapped read counts, whatever the register
  assign rd_hit = access && !pwrite && mapped;

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= thermal_pkg::RST_CONFIG;
      hyst_q <= thermal_pkg::RST_HYST;
      low_q <= thermal_pkg::RST_LOW;
      high_q <= thermal_pkg::RST_HIGH;
      crit_q <= thermal_pkg::RST_CRIT;
    end else if (access && pwrite && writable) begin
      unique case (paddr)
        thermal_pkg::OFF_CONFIG: config_q <= pwdata[3:0];
        thermal_pkg::OFF_HYST: hyst_q <= pwdata[9:0];
        thermal_pkg::OFF_LOW: low_q <= pwdata[9:0];
        thermal_pkg::OFF_HIGH: high_q <= pwdata[9:0];
        thermal_pkg::OFF_CRIT: crit_q <= pwdata[9:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped || (pwrite && !writable);
      prdata <= '0;
      unique case (paddr)
        thermal_pkg::OFF_TEMP: prdata[9:0] <= temp_q;
        thermal_pkg::OFF_CONFIG: prdata[3:0] <= config_q;
        thermal_pkg::OFF_HYST: prdata[9:0] <= hyst_q;
        thermal_pkg::OFF_LOW: prdata[9:0] <= low_q;
        thermal_pkg::OFF_HIGH: prdata[9:0] <= high_q;
        thermal_pkg::OFF_CRIT: prdata[9:0] <= crit_q;
        thermal_pkg::OFF_STATUS: begin
          prdata[thermal_pkg::ST_FLAGS_LSB +: 3] <= flag_q;
          prdata[thermal_pkg::ST_WIN] <= win_alarm_q;
          prdata[thermal_pkg::ST_CRIT] <= crit_alarm_q;
          prdata[thermal_pkg::ST_BUSY] <=
            !config_q[thermal_pkg::CFG_SHUTDOWN];
          prdata[thermal_pkg::ST_ADDR_LSB +: 7] <= bus_addr_q;
        end
        default: ;
      endcase
    end
  end

endmodule

/* File: common/thermal_pkg.sv */
/*
 * constants for the thermal window comparator: register map, field
 * positions, reset values and conversion timing.
 * assumes a 10 mhz pclk and 32-bit apb data.
 */
package thermal_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int TEMP_W = 10;
  localparam int ADDR_W = 8;
  localparam int CONV_W = 20;
  localparam int FQ_W = 3;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_TEMP = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_HYST = 8'h08;
  localparam logic [7:0] OFF_LOW = 8'h0C;
  localparam logic [7:0] OFF_HIGH = 8'h10;
  localparam logic [7:0] OFF_CRIT = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_EVENT = 1;
  localparam int CFG_FQ_LSB = 2;
  localparam int ST_FLAGS_LSB = 0;
  localparam int ST_WIN = 3;
  localparam int ST_CRIT = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_ADDR_LSB = 8;

  // ----------------------------------------
  // reset values, 0.5 degree per lsb
  // ----------------------------------------
  localparam logic [9:0] RST_HYST = 10'h004;
  localparam logic [9:0] RST_LOW = 10'h014;
  localparam logic [9:0] RST_HIGH = 10'h080;
  localparam logic [9:0] RST_CRIT = 10'h0A0;
  localparam logic [3:0] RST_CONFIG = 4'h0;

  // ----------------------------------------
  // fault queue depths, by config code
  // ----------------------------------------
  localparam logic [2:0] FQ_DEPTH0 = 3'h1;
  localparam logic [2:0] FQ_DEPTH1 = 3'h2;
  localparam logic [2:0] FQ_DEPTH2 = 3'h4;
  localparam logic [2:0] FQ_DEPTH3 = 3'h6;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CONV_TIME_MS = 70;
  localparam int CONV_CYCLES = CONV_TIME_MS * (CLK_HZ / 1000);

  // upper five bits of the serial address; arbitrary value
  localparam logic [4:0] BUS_ADDR_BASE = 5'h00;

endpackage

/* File: common/pin_sync_if.sv */
/*
 * carrier between a pin synchroniser and its user: raw pin levels in,
 * filtered levels out.
 * assumes the user and the synchroniser share pclk.
 */
`timescale 1ns/10ps
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface

/* File: logic/pin_sync.sv */
/*
 * three-stage synchroniser with agreement filter for pin inputs.
 * assumes pins are asynchronous to pclk and change slowly against it.
 */
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  pin_sync_if.sync_side sig
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;

  // ----------------------------------------
  // stages
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= sig.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit moves only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean_q <= '0;
    end else begin
      clean_q <= (s2_q & ~(s2_q ^ s3_q)) | (clean_q & (s2_q ^ s3_q));
    end
  end

  assign sig.clean = clean_q;

endmodule

/* File: dv/thermal_monitor.sv */
/* port checker for the comparator core.
   assumes pclk domain only, bound to every core instance. */
`timescale 1ns/10ps
module thermal_monitor #(
  parameter int unsigned CONV_CYCLES = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic window_alarm_out,
  input wire logic window_alarm_oe_n,
  input wire logic critical_alarm_out,
  input wire logic critical_alarm_oe_n
);
  // ----
  // cycles since the last mapped read
  // ----
  // wide enough to span a full-length conversion period
  logic [19:0] since_rd_q;
  logic rd_hit;
  assign rd_hit = psel && penable && !pwrite && paddr <= 8'h18
    && paddr[1:0] == 2'b00;
  // saturates so the count never wraps into the alarm window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rd_q <= 20'hF_FFFF;
    end else if (rd_hit) begin
      since_rd_q <= 20'h0_0000;
    end else if (since_rd_q != 20'hF_FFFF) begin
      since_rd_q <= since_rd_q + 20'h0_0001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_acc_s;
    psel && penable && !pwrite;
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_pins_low: assert property (!window_alarm_out && !critical_alarm_out)
    else $error("alarm pin driven high");
  chk_bad_addr: assert property (setup_s ##0 (paddr > 8'h18
    || paddr[1:0] != 2'b00) |=> pslverr) else $error("no slave error");
  chk_setpt_ok: assert property (setup_s ##0 (pwrite && paddr >= 8'h08
    && paddr <= 8'h14 && paddr[1:0] == 2'b00) |=> !pslverr)
    else $error("setpoint write refused");
  chk_err_zero: assert property (rd_acc_s ##0 pslverr |-> prdata == 0)
    else $error("refused read data not zero");
  chk_temp_width: assert property (rd_acc_s ##0 paddr == 8'h00
    |-> prdata[31:10] == 0) else $error("result wider than 10 bits");
  chk_strap_addr: assert property (rd_acc_s ##0 paddr == 8'h18
    |-> prdata[14:8] == {5'h00, addr_strap_bit1, addr_strap_bit0})
    else $error("bus address wrong");
  chk_win_rearm: assert property ($fell(window_alarm_oe_n)
    |-> since_rd_q <= 1 || since_rd_q >= CONV_CYCLES - 2)
    else $error("window alarm set between conversions");
  chk_crit_rearm: assert property ($fell(critical_alarm_oe_n)
    |-> since_rd_q <= 1 || since_rd_q >= CONV_CYCLES - 2)
    else $error("critical alarm set between conversions");
endmodule

bind thermal_window_comparator thermal_monitor #(
  .CONV_CYCLES(CONV_CYCLES)
) mon_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .addr_strap_bit0, .addr_strap_bit1,
  .window_alarm_out, .window_alarm_oe_n, .critical_alarm_out,
  .critical_alarm_oe_n);

/* File: dv/sens_model.sv */
/* serial front end that delivers one 10-bit sample per frame.
   assumes the core samples the link with its own clock. */
`timescale 1ns/10ps
module sens_model (
  output logic sens_clk,
  output logic sens_dat,
  output logic sens_frame
);
  // ----
  // frame sender, link clock parked low between frames
  // ----
  initial begin
    sens_clk = 1'b0;
    sens_dat = 1'b0;
    sens_frame = 1'b0;
  end
  task automatic send(input logic [9:0] v);
    // keeps every link edge off a pclk edge
    #30;
    sens_frame = 1'b1;
    for (int i = 9; i >= 0; i--) begin
      sens_dat = v[i];
      #400 sens_clk = 1'b1;
      #400 sens_clk = 1'b0;
    end
    sens_frame = 1'b0;
    // idle line shows garbage, not the last bit
    sens_dat = ~v[0];
  endtask
endmodule

/* File: dv/thermal_window_comparator_tb.sv */
/* self-checking bench for the comparator core.
   assumes the monitor bind and the front-end model are compiled. */
`timescale 1ns/10ps
module thermal_window_comparator_tb;
  localparam int unsigned CONV = 200;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, sens_clk, sens_dat, sens_frame;
  logic wa_out, wa_oe_n, ca_out, ca_oe_n;
  logic [31:0] rd;
  logic err;
  logic strap0 = 1'b1;
  logic strap1 = 1'b0;
  int errors = 0;
  int n_tests = 0;
  always #50 pclk = ~pclk;
  sens_model part_u (.sens_clk, .sens_dat, .sens_frame);
  thermal_window_comparator #(.CONV_CYCLES(CONV)) dut_u (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .sens_clk, .sens_dat, .sens_frame, .addr_strap_bit0(strap0),
    .addr_strap_bit1(strap1), .window_alarm_in(wa_oe_n | wa_out),
    .window_alarm_out(wa_out), .window_alarm_oe_n(wa_oe_n),
    .critical_alarm_in(ca_oe_n | ca_out), .critical_alarm_out(ca_out),
    .critical_alarm_oe_n(ca_oe_n));
  // ----
  // shared tasks
  // ----
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic put(input logic [9:0] t, input int n);
    part_u.send(t);
    repeat (n * CONV + 10) @(posedge pclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_defaults;
    rdc("hyst", thermal_pkg::OFF_HYST, 32'h0000_0004);
    rdc("low", thermal_pkg::OFF_LOW, 32'h0000_0014);
    rdc("high", thermal_pkg::OFF_HIGH, 32'h0000_0080);
    rdc("crit", thermal_pkg::OFF_CRIT, 32'h0000_00A0);
    rdc("status", thermal_pkg::OFF_STATUS, 32'h0000_0120);
    strap0 <= 1'b0;
    strap1 <= 1'b1;
    repeat (5) @(posedge pclk);
    rdc("strap swap", thermal_pkg::OFF_STATUS, 32'h0000_0220);
    strap0 <= 1'b1;
    strap1 <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask
  task automatic t_setpoints;
    apb(1'b1, thermal_pkg::OFF_CRIT, 32'h0000_00B0);
    rdc("crit wr", thermal_pkg::OFF_CRIT, 32'h0000_00B0);
    apb(1'b1, 8'h1C, 32'h0000_0001);
    chk("unmapped err", 32'h0000_0001, err);
    rdc("unmapped rd", 8'h1C, 32'h0000_0000);
    chk("unmapped rd err", 32'h0000_0001, err);
    apb(1'b1, thermal_pkg::OFF_TEMP, 32'h0000_0001);
    chk("ro err", 32'h0000_0001, err);
  endtask
  task automatic t_hot;
    put(10'h0C8, 2);
    chk("crit on", 32'h0000_0000, ca_oe_n);
    chk("win on", 32'h0000_0000, wa_oe_n);
    rdc("temp", thermal_pkg::OFF_TEMP, 32'h0000_00C8);
    @(posedge pclk);
    chk("crit read", 32'h0000_0001, ca_oe_n);
    chk("win read", 32'h0000_0001, wa_oe_n);
    repeat (CONV + 10) @(posedge pclk);
    chk("crit again", 32'h0000_0000, ca_oe_n);
    chk("win again", 32'h0000_0000, wa_oe_n);
  endtask
  task automatic hysteresis_setpoint;
    put(10'h0AE, 2);
    chk("crit hold", 32'h0000_0000, ca_oe_n);
    put(10'h0AB, 2);
    chk("crit off", 32'h0000_0001, ca_oe_n);
    put(10'h3F0, 2);
    rdc("neg status", thermal_pkg::OFF_STATUS, 32'h0000_0129);
    rdc("flags kept", thermal_pkg::OFF_STATUS, 32'h0000_0121);
    put(10'h017, 2);
    chk("low hold", 32'h0000_0000, wa_oe_n);
    put(10'h019, 2);
    chk("low off", 32'h0000_0001, wa_oe_n);
  endtask
  task automatic t_event;
    apb(1'b1, thermal_pkg::OFF_CONFIG, 32'h0000_0002);
    put(10'h3F0, 2);
    chk("ev set", 32'h0000_0000, wa_oe_n);
    rdc("ev clr", thermal_pkg::OFF_CONFIG, 32'h0000_0002);
    repeat (2 * CONV) @(posedge pclk);
    chk("ev held", 32'h0000_0001, wa_oe_n);
    put(10'h020, 2);
    chk("ev release", 32'h0000_0000, wa_oe_n);
  endtask
  task automatic t_fault;
    apb(1'b1, thermal_pkg::OFF_CONFIG, 32'h0000_0004);
    part_u.send(10'h0C8);
    rdc("fq cfg", thermal_pkg::OFF_CONFIG, 32'h0000_0004);
    repeat (CONV + 5) @(posedge pclk);
    chk("fq one", 32'h0000_0001, wa_oe_n);
    repeat (CONV) @(posedge pclk);
    chk("fq two", 32'h0000_0000, wa_oe_n);
  endtask
  task automatic t_shutdown;
    apb(1'b1, thermal_pkg::OFF_CONFIG, 32'h0000_0001);
    apb(1'b0, thermal_pkg::OFF_STATUS, 32'h0000_0000);
    chk("busy", 32'h0000_0000, rd[5]);
    put(10'h060, 2);
    rdc("temp kept", thermal_pkg::OFF_TEMP, 32'h0000_00C8);
    apb(1'b1, thermal_pkg::OFF_CONFIG, 32'h0000_0000);
    // a read before the period ends must push the next result out
    repeat (CONV - 50) @(posedge pclk);
    rdc("temp abort", thermal_pkg::OFF_TEMP, 32'h0000_00C8);
    repeat (100) @(posedge pclk);
    rdc("temp restart", thermal_pkg::OFF_TEMP, 32'h0000_00C8);
    repeat (CONV + 10) @(posedge pclk);
    rdc("temp new", thermal_pkg::OFF_TEMP, 32'h0000_0060);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_setpoints();
    t_hot();
    hysteresis_setpoint();
    t_event();
    t_fault();
    t_shutdown();
    end_of_test();
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    end_of_test();
  end
endmodule
